// [rtl/io_err_defines.svh]
// constants for the load/store error reporter: codes, field positions,
// reset values and timing
// assumes a 20 MHz system clock
`ifndef IO_ERR_DEFINES_SVH
`define IO_ERR_DEFINES_SVH

// ************************************************
// error codes logged into the status field
// ************************************************
`define ERR_NONE 4'h0
`define ERR_INVALID 4'h1
`define ERR_AUTH 4'h5
`define ERR_CHCK 4'h8
`define ERR_PARITY 4'h9
`define ERR_CARDFB 4'hA
`define ERR_XLATE_RELOAD 4'hB

// ************************************************
// status register layout and reset values
// ************************************************
`define ERR_CODE_LSB 16
`define ERR_CODE_MSB 19
`define STATUS_RST 32'h0000_0000

// ************************************************
// timing
// ************************************************
`define SYS_CLK_NS 50
`define BM_CHCK_NS 100

`endif

// [rtl/io_err_pkg.sv]
// types shared by the load/store error reporter
// assumes the defines header supplies the numeric constants
package io_err_pkg;

    localparam int PROC_W = 2;
    localparam int MASK_W = 4;

    // one processor load or store as decoded by the front end
    typedef struct packed {
        logic isStore;
        logic isFacility;
        logic [PROC_W-1:0] procId;
        logic protectBit;
        logic [MASK_W-1:0] authMask;
        logic xlateValid;
        logic [MASK_W-1:0] xlateKey;
        logic xlateReloadErr;
        logic lenOk;
        logic undefAddr;
        logic segCross;
    } acc_req_t;

    // completion of the expansion-bus cycle
    typedef struct packed {
        logic done;
        logic parityErr;
        logic cardFbErr;
        logic syncChck;
    } bus_rsp_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CHECK = 4'h2,
        ST_BUS = 4'h4,
        ST_RESP = 4'h8
    } state_t;

endpackage : io_err_pkg

// [rtl/sync_ff.sv]
// two flip-flop synchroniser for pin inputs
// assumes a single system clock and asynchronous active-high reset
`timescale 1ns/1ps

module sync_ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input logic sys_clk,
    input logic rst,
    input logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule : sync_ff

// [rtl/io_load_store_error_reporter.sv]
// error classification and reporting for processor loads and stores
// through the io_channel_controller
//
// Rules for this block, the bus adapters and software
// RULE1: recoverable error raises DSI and logs code
// RULE2: synchronous bus error code into bits 16-19
// RULE3: DSI precise and ordered with the access
// RULE4: async channel check sets miscellaneous interrupt
// RULE5: check present at bus start also gives DSI
// RULE6: only one error status is held
// RULE7: protect bit set gives invalid operation
// RULE8: undefined control address gives invalid operation
// RULE9: missing entry with nonzero mask gives invalid
// RULE10: wrong facility length gives invalid operation
// RULE11: facility access with nonzero mask is invalid
// RULE12: segment crossing may flag invalid operation
// RULE13: key and mask mismatch gives authority error
// RULE14: listed error classes are reported as recoverable
// RULE15: crossing and reload errors reported as recoverable
// RULE16: bus master error returns synchronous channel check
// RULE17: adapters should not raise checks asynchronously
// RULE18: software retries a failed access three times
// RULE19: reserved codes never logged
//
// assumes one access outstanding; front end holds decode fields valid
// with accValid; the channel check pin is active low and open drain
`timescale 1ns/1ps
`include "io_err_defines.svh"

module io_load_store_error_reporter
    import io_err_pkg::*;
#(
    parameter bit SEG_CROSS_EN = 1'b1
) (
    input logic sys_clk,
    input logic rst,
    input logic accValid,
    input acc_req_t accReq,
    output logic accReady,
    output logic accDone,
    output logic accDsi,
    output logic busStart,
    input bus_rsp_t busRsp,
    output logic [31:0] storageErrorStatus,
    output logic [PROC_W-1:0] statusProc,
    output logic statusValid,
    input logic statusClr,
    output logic irqMisc,
    input logic irqMiscClr,
    input logic chckPin_n_i,
    output logic chckPin_n_o,
    output logic chckPin_n_oe,
    input logic bmErr,
    output logic bmDriverErr,
    input logic bmDriverClr
);

    // ************************************************
    // timing
    // ************************************************
    localparam int CHCK_CYC_I = (`BM_CHCK_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS;
    localparam logic [3:0] CHCK_CYC = 4'(CHCK_CYC_I > 0 ? CHCK_CYC_I : 1);

    // ************************************************
    // state
    // ************************************************
    state_t state_q, state_d;
    acc_req_t req_q;
    logic [3:0] errCode_q;
    logic errPend_q;
    logic chckAtStart_q;
    logic accReady_q, accDone_q, accDsi_q, busStart_q;
    logic [31:0] status_q;
    logic [PROC_W-1:0] statusProc_q;
    logic statusValid_q;
    logic irqMisc_q;
    logic chckOe_q, chckOut_q;
    logic [3:0] chckCnt_q;
    logic [1:0] oeDly_q;
    logic bmDriverErr_q;
    logic chckSync_n, chckSync;
    logic [3:0] decodeCode, busCode;
    logic capture, ownDrive;

    // channel check pin into the clock domain
    sync_ff #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_chck_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(chckPin_n_i),
        .dout(chckSync_n)
    );
    assign chckSync = ~chckSync_n;

    // ************************************************
    // decode checks, first match wins
    // ************************************************
    always_comb begin
        decodeCode = `ERR_NONE;
        if (req_q.protectBit) begin
            decodeCode = `ERR_INVALID; // [RULE7]
        end else if (req_q.isFacility && req_q.undefAddr) begin
            decodeCode = `ERR_INVALID; // [RULE8]
        end else if (req_q.isFacility && !req_q.lenOk) begin
            decodeCode = `ERR_INVALID; // [RULE10]
        end else if (req_q.isFacility && req_q.authMask != '0) begin
            decodeCode = `ERR_INVALID; // [RULE11]
        end else if (SEG_CROSS_EN && req_q.segCross) begin
            decodeCode = `ERR_INVALID; // [RULE12] [RULE15]
        end else if (!req_q.isFacility && req_q.authMask != '0) begin
            if (!req_q.xlateValid) begin
                decodeCode = `ERR_INVALID; // [RULE9]
            end else if (req_q.xlateReloadErr) begin
                decodeCode = `ERR_XLATE_RELOAD; // [RULE15]
            end else if (req_q.xlateKey != req_q.authMask || req_q.xlateKey == '0) begin
                decodeCode = `ERR_AUTH; // [RULE13]
            end
        end
    end

    // bus completion classes, check present at start first
    always_comb begin
        busCode = `ERR_NONE;
        if (chckAtStart_q || busRsp.syncChck) begin
            busCode = `ERR_CHCK; // [RULE5] [RULE14]
        end else if (busRsp.parityErr) begin
            busCode = `ERR_PARITY; // [RULE14]
        end else if (busRsp.cardFbErr) begin
            busCode = `ERR_CARDFB; // [RULE14]
        end
    end

    // ************************************************
    // access sequencer
    // ************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (accValid) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (decodeCode != `ERR_NONE || req_q.isFacility) begin
                    state_d = ST_RESP;
                end else begin
                    state_d = ST_BUS;
                end
            end
            ST_BUS: begin
                if (busRsp.done) begin
                    state_d = ST_RESP;
                end
            end
            ST_RESP: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state register and latched request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            req_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && accValid) begin
                req_q <= accReq;
            end
        end
    end

    // pending error for the access in flight
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            errCode_q <= `ERR_NONE;
            errPend_q <= 1'b0;
            chckAtStart_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    errCode_q <= `ERR_NONE;
                    errPend_q <= 1'b0;
                    chckAtStart_q <= 1'b0;
                end
                ST_CHECK: begin
                    errCode_q <= decodeCode;
                    errPend_q <= decodeCode != `ERR_NONE;
                    chckAtStart_q <= chckSync; // [RULE5]
                end
                ST_BUS: begin
                    if (busRsp.done) begin
                        errCode_q <= busCode; // [RULE2]
                        errPend_q <= busCode != `ERR_NONE;
                    end
                end
                default: begin
                    errCode_q <= errCode_q;
                end
            endcase
        end
    end

    // handshake: answer tied to the same access, one at a time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            accReady_q <= 1'b1;
            accDone_q <= 1'b0;
            accDsi_q <= 1'b0;
            busStart_q <= 1'b0;
        end else begin
            accReady_q <= state_d == ST_IDLE; // [RULE3]
            accDone_q <= state_q == ST_RESP;
            accDsi_q <= state_q == ST_RESP && errPend_q; // [RULE1] [RULE3]
            busStart_q <= state_q == ST_CHECK && state_d == ST_BUS;
        end
    end

    // ************************************************
    // error status, first error held until cleared
    // ************************************************
    assign capture = state_q == ST_RESP && errPend_q && (!statusValid_q || statusClr);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_q <= `STATUS_RST;
            statusProc_q <= '0;
            statusValid_q <= 1'b0;
        end else if (capture) begin
            status_q <= `STATUS_RST;
            status_q[`ERR_CODE_MSB:`ERR_CODE_LSB] <= errCode_q; // [RULE1] [RULE2]
            statusProc_q <= req_q.procId;
            statusValid_q <= 1'b1; // [RULE6]
        end else if (statusClr) begin
            status_q <= `STATUS_RST;
            statusValid_q <= 1'b0;
        end
    end

    // ************************************************
    // channel check pin, miscellaneous interrupt
    // ************************************************
    assign ownDrive = chckOe_q || oeDly_q != 2'b00;

    // async check outside a bus cycle; our own drive is masked
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqMisc_q <= 1'b0;
        end else if (chckSync && state_q != ST_BUS && !ownDrive) begin
            irqMisc_q <= 1'b1; // [RULE4] [RULE17]
        end else if (irqMiscClr) begin
            irqMisc_q <= 1'b0;
        end
    end

    // bus master error: pull check low for a fixed time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chckOe_q <= 1'b0;
            chckOut_q <= 1'b0;
            chckCnt_q <= 4'h0;
            oeDly_q <= 2'b00;
        end else begin
            oeDly_q <= {oeDly_q[0], chckOe_q};
            chckOut_q <= 1'b0;
            if (bmErr) begin
                chckOe_q <= 1'b1; // [RULE16]
                chckCnt_q <= CHCK_CYC;
            end else if (chckCnt_q > 4'h1) begin
                chckCnt_q <= chckCnt_q - 4'h1;
            end else begin
                chckOe_q <= 1'b0;
                chckCnt_q <= 4'h0;
            end
        end
    end

    // driver-side flag for the same bus master error
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bmDriverErr_q <= 1'b0;
        end else if (bmErr) begin
            bmDriverErr_q <= 1'b1; // [RULE16]
        end else if (bmDriverClr) begin
            bmDriverErr_q <= 1'b0;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign accReady = accReady_q;
    assign accDone = accDone_q;
    assign accDsi = accDsi_q;
    assign busStart = busStart_q;
    assign storageErrorStatus = status_q;
    assign statusProc = statusProc_q;
    assign statusValid = statusValid_q;
    assign irqMisc = irqMisc_q;
    assign chckPin_n_o = chckOut_q;
    assign chckPin_n_oe = chckOe_q;
    assign bmDriverErr = bmDriverErr_q;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    dsi_logged_a: assert property ( // [RULE1]
        accDsi_q |-> statusValid_q)
        else $error("dsi without logged status");

    code_field_a: assert property ( // [RULE2]
        statusValid_q |-> status_q[31:20] == 12'h000 && status_q[15:0] == 16'h0000)
        else $error("status bits outside code field");

    no_reserved_a: assert property ( // [RULE19]
        statusValid_q |-> !(status_q[19:16] inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7}))
        else $error("reserved error code logged");

    one_access_a: assert property ( // [RULE3]
        accValid && accReady_q |=> !accReady_q ##1 !accReady_q)
        else $error("second access accepted while busy");

    done_ready_a: assert property ( // [RULE3]
        accDone_q |-> accReady_q && !$past(accReady_q))
        else $error("answer not paired with access");

    misc_irq_a: assert property ( // [RULE4]
        chckSync && state_q != ST_BUS && !ownDrive |=> irqMisc_q)
        else $error("async check not reported");

    chck_latch_a: assert property ( // [RULE5]
        state_q == ST_CHECK && state_d == ST_BUS && chckSync |=> chckAtStart_q)
        else $error("check at bus start not latched");

    chck_start_a: assert property ( // [RULE5]
        state_q == ST_BUS && busRsp.done && chckAtStart_q |=> errCode_q == `ERR_CHCK && errPend_q)
        else $error("check at start not logged");

    single_status_a: assert property ( // [RULE6]
        statusValid_q && !statusClr |=> $stable(status_q) && $stable(statusProc_q))
        else $error("held status overwritten");

    protect_bit_a: assert property ( // [RULE7]
        state_q == ST_CHECK && req_q.protectBit |=> errCode_q == `ERR_INVALID && errPend_q)
        else $error("protect bit not flagged invalid");

    fac_mask_a: assert property ( // [RULE11]
        state_q == ST_CHECK && req_q.isFacility && req_q.authMask != '0
        |=> errCode_q == `ERR_INVALID)
        else $error("facility mask not flagged invalid");

    bm_chck_a: assert property ( // [RULE16]
        bmErr |=> chckOe_q [*2] ##1 (!chckOe_q || $past(bmErr) || $past(bmErr, 2)))
        else $error("bus master check width wrong");

endmodule : io_load_store_error_reporter

// [verif/bus_adapter_model.sv]
// expansion-bus adapter model facing the error reporter
// assumes the bench sets delay, error flags and the raw check request
`timescale 1ns/1ps

module bus_adapter_model
    import io_err_pkg::*;
(
    input logic sys_clk,
    input logic rst,
    input logic busStart,
    input logic [3:0] rspDelay,
    input logic [2:0] rspErr,
    input logic chckHold,
    input logic chckPin_n_o,
    input logic chckPin_n_oe,
    output bus_rsp_t busRsp,
    output logic pinLevel
);
    // ************************************************
    // bus cycle timing
    // ************************************************
    logic [3:0] cntQ;
    logic pendQ;
    logic fire;

    assign fire = pendQ && (cntQ == 4'h0);

    // wait the commanded number of cycles after the start pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pendQ <= 1'b0;
            cntQ <= 4'h0;
        end else if (busStart) begin
            pendQ <= 1'b1;
            cntQ <= rspDelay;
        end else if (fire) begin
            pendQ <= 1'b0;
        end else if (pendQ) begin
            cntQ <= cntQ - 4'h1;
        end
    end

    // flags only mean something with done, so they wobble otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busRsp <= '0;
        end else if (fire) begin
            busRsp <= {1'b1, rspErr[0], rspErr[1], rspErr[2]};
        end else begin
            busRsp <= {1'b0, ~busRsp.parityErr, ~busRsp.cardFbErr, ~busRsp.syncChck};
        end
    end

    // open-drain check line with pull-up; chckHold is a misbehaving card
    assign pinLevel = ~((chckPin_n_oe & ~chckPin_n_o) | chckHold);
endmodule : bus_adapter_model

// [verif/tb.sv]
// self-checking bench for the load/store error reporter
// assumes the adapter model on the bus side and a 20 MHz clock
`timescale 1ns/1ps
`include "io_err_defines.svh"

module tb;
    import io_err_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic accValid = 1'b0, statusClr = 1'b0, irqMiscClr = 1'b0;
    logic bmErr = 1'b0, bmDriverClr = 1'b0, chckHold = 1'b0;
    acc_req_t accReq = '0;
    logic [3:0] rspDelay = 4'h0;
    logic [2:0] rspErr = 3'h0;
    logic accReady, accDone, accDsi, busStart, statusValid, irqMisc;
    logic chckPin_n_o, chckPin_n_oe, bmDriverErr, pinLevel;
    logic [31:0] storageErrorStatus;
    logic [PROC_W-1:0] statusProc;
    bus_rsp_t busRsp;
    int err_total = 0;
    int check_count = 0;

    always #25 sys_clk = ~sys_clk;

    io_load_store_error_reporter u_dut (.sys_clk(sys_clk), .rst(rst), .accValid(accValid),
        .accReq(accReq), .accReady(accReady), .accDone(accDone), .accDsi(accDsi),
        .busStart(busStart), .busRsp(busRsp), .storageErrorStatus(storageErrorStatus),
        .statusProc(statusProc), .statusValid(statusValid), .statusClr(statusClr),
        .irqMisc(irqMisc), .irqMiscClr(irqMiscClr), .chckPin_n_i(pinLevel),
        .chckPin_n_o(chckPin_n_o), .chckPin_n_oe(chckPin_n_oe), .bmErr(bmErr),
        .bmDriverErr(bmDriverErr), .bmDriverClr(bmDriverClr));

    bus_adapter_model u_bus (.sys_clk(sys_clk), .rst(rst), .busStart(busStart),
        .rspDelay(rspDelay), .rspErr(rspErr), .chckHold(chckHold),
        .chckPin_n_o(chckPin_n_o), .chckPin_n_oe(chckPin_n_oe), .busRsp(busRsp),
        .pinLevel(pinLevel));

    // ************************************************
    // helpers
    // ************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] word(input logic [3:0] code);
        return 32'(code) << `ERR_CODE_LSB;
    endfunction : word

    // one access: hold valid until taken, then wait for completion
    task automatic acc(input acc_req_t r, input logic [2:0] err, input logic [3:0] code);
        int n;
        @(posedge sys_clk);
        accValid <= 1'b1;
        accReq <= r;
        rspErr <= err;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (accReady !== 1'b1 && n < 20);
        accValid <= 1'b0;
        if (n >= 20) begin
            err_total++;
            stop_test();
        end
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (accDone !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_total++;
            stop_test();
        end
        chk(accDsi, code != 4'h0);
    endtask : acc

    // one-cycle pulse on a clear input: 0 status, 1 misc irq, 2 driver flag
    task automatic pulse(input int which);
        @(posedge sys_clk);
        statusClr <= (which == 0);
        irqMiscClr <= (which == 1);
        bmDriverClr <= (which == 2);
        @(posedge sys_clk);
        statusClr <= 1'b0;
        irqMiscClr <= 1'b0;
        bmDriverClr <= 1'b0;
        #1;
    endtask : pulse

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        acc_req_t base, r;
        logic [3:0] code;
        logic [3:0] bcode [4] = '{`ERR_PARITY, `ERR_CARDFB, `ERR_CHCK, `ERR_CHCK};
        logic [2:0] berr [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
        int n;
        base = '0;
        base.lenOk = 1'b1;
        base.xlateValid = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        // clean accesses: fast bus, slow bus, facility
        acc(base, 3'h0, `ERR_NONE);
        rspDelay <= 4'h9;
        acc(base, 3'h0, `ERR_NONE);
        r = base;
        r.isFacility = 1'b1;
        acc(r, 3'h0, `ERR_NONE);
        chk(statusValid, 1'b0);
        $display("test clean done");
        // decode error table
        rspDelay <= 4'h0;
        for (int i = 0; i < 10; i++) begin
            pulse(0);
            r = base;
            r.procId = i[1:0];
            r.authMask = (i == 2 || i > 5) ? 4'h3 : 4'h0;
            case (i)
                0: r.protectBit = 1'b1;
                1: begin r.isFacility = 1'b1; r.undefAddr = 1'b1; end
                2: r.xlateValid = 1'b0;
                3: begin r.isFacility = 1'b1; r.lenOk = 1'b0; end
                4: begin r.isFacility = 1'b1; r.authMask = 4'h2; end
                5: r.segCross = 1'b1;
                6: r.xlateKey = 4'h5;
                7: r.xlateKey = 4'h0;
                8: r.xlateReloadErr = 1'b1;
                default: r.xlateKey = 4'h3;
            endcase
            code = (i < 6) ? `ERR_INVALID : (i < 8) ? `ERR_AUTH : 4'h0;
            code = (i == 8) ? `ERR_XLATE_RELOAD : code;
            acc(r, 3'h0, code);
            chk(storageErrorStatus, word(code));
            chk(statusValid, code != 4'h0);
            if (code != 4'h0) chk(statusProc, i[1:0]);
        end
        $display("test decode done");
        // bus-side errors, slow answer, priority when all flags set
        rspDelay <= 4'h6;
        for (int j = 0; j < 4; j++) begin
            pulse(0);
            acc(base, berr[j], bcode[j]);
            chk(storageErrorStatus, word(bcode[j]));
        end
        $display("test bus errors done");
        // software retries three times; only the first error is held
        pulse(0);
        repeat (3) acc(base, 3'h1, `ERR_PARITY);
        r = base;
        r.protectBit = 1'b1;
        acc(r, 3'h0, `ERR_INVALID);
        chk(storageErrorStatus, word(`ERR_PARITY));
        $display("test single status done");
        // asynchronous channel check: misc irq, then an access while held
        pulse(0);
        @(posedge sys_clk);
        chckHold <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (irqMisc !== 1'b1 && n < 8);
        chk(irqMisc, 1'b1);
        if (irqMisc !== 1'b1) begin
            stop_test();
        end
        acc(base, 3'h0, `ERR_CHCK);
        chk(storageErrorStatus, word(`ERR_CHCK));
        @(posedge sys_clk);
        chckHold <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pulse(1);
        chk(irqMisc, 1'b0);
        $display("test channel check done");
        // bus master error drives the check line for two cycles
        @(posedge sys_clk);
        bmErr <= 1'b1;
        @(posedge sys_clk);
        bmErr <= 1'b0;
        #1;
        chk({chckPin_n_oe, chckPin_n_o, bmDriverErr}, 3'b101);
        @(posedge sys_clk);
        #1;
        chk(chckPin_n_oe, 1'b1);
        @(posedge sys_clk);
        #1;
        chk(chckPin_n_oe, 1'b0);
        repeat (6) @(posedge sys_clk);
        #1;
        chk(irqMisc, 1'b0);
        pulse(2);
        chk(bmDriverErr, 1'b0);
        $display("test bus master done");
        stop_test();
    end
endmodule : tb
